// [rtl/async_read_defs.svh]
`ifndef ASYNC_READ_DEFS_SVH
`define ASYNC_READ_DEFS_SVH
`define ADDR_W 24
`define DATA_W 16
`define BE_W 2
`define BANK_W 4
`define CNT_W 8
`define MODE_ASYNC 2'h0
`define CLKOUT_SEL_SYS0 4'h3
`define READY_RELEASE_CYCLES 8'h03
`endif

// [rtl/async_read_pkg.sv]
`include "async_read_defs.svh"
`default_nettype none
package async_read_pkg;
   typedef struct packed {
      logic [`CNT_W-1:0] pre_setup_cycles;
      logic [`CNT_W-1:0] read_setup_cycles;
      logic [`CNT_W-1:0] pre_access_cycles;
      logic [`CNT_W-1:0] read_access_cycles;
      logic [`CNT_W-1:0] read_hold_cycles;
   } timing_type;
   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [`BANK_W-1:0] bank;
      logic [`BE_W-1:0] byte_en;
   } request_type;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRE_SETUP = 3'b001,
      ST_SETUP = 3'b010,
      ST_PRE_ACCESS = 3'b011,
      ST_ACCESS = 3'b100,
      ST_HOLD = 3'b101
   } phase_type;
endpackage
`default_nettype wire

// [rtl/async_memory_read_sequencer.sv]
`include "async_read_defs.svh"
`default_nettype none
// How it works
// - Reads run only in bank mode 00
// - Address, bank select lead strobe by three phases
// - Output enable leads strobe by setup+preaccess
// - Pre-access count after address valid rises
// - Strobe low exactly access count without ready
// - Outputs held for hold count after strobe
// - Strobe released within 3 cycles of ready
// - Data captured when read strobe rises
// - Selector 3 mirrors system clock on pin
// - Address valid low for setup count
module async_memory_read_sequencer (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // Configuration
   input wire logic [1:0] i_bank_mode,
   input wire logic i_ready_wait_en,
   input wire logic [3:0] i_clkout_source_sel,
   input wire async_read_pkg::timing_type i_timing,
   // Request and answer
   input wire logic i_req,
   input wire async_read_pkg::request_type i_request,
   output logic o_busy,
   output logic o_done,
   output logic [`DATA_W-1:0] o_rdata,
   // Memory pins
   output logic [`ADDR_W-1:0] o_addr_bus,
   output logic [`BANK_W-1:0] o_bank_select_n,
   output logic [`BE_W-1:0] o_byte_enable_n,
   output logic o_output_enable_n,
   output logic o_read_strobe_n,
   output logic o_addr_valid_n,
   output logic o_clkout_en,
   input wire logic [`DATA_W-1:0] i_data_bus,
   input wire logic i_ext_ready
);
   import async_read_pkg::*;

   phase_type phase_reg;
   logic [`CNT_W-1:0] count_reg;
   timing_type timing_reg;
   logic ready_s1_reg;
   logic ready_s2_reg;
   logic [`DATA_W-1:0] data_s1_reg;
   logic [`DATA_W-1:0] data_s2_reg;
   logic last;

   assign last = (count_reg <= 8'h01);

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ready_s1_reg <= 1'b0;
         ready_s2_reg <= 1'b0;
         data_s1_reg <= '0;
         data_s2_reg <= '0;
      end else begin
         ready_s1_reg <= i_ext_ready;
         ready_s2_reg <= ready_s1_reg;
         data_s1_reg <= i_data_bus;
         data_s2_reg <= data_s1_reg;
      end
   end

   // Phase sequencer
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         phase_reg <= ST_IDLE;
         count_reg <= '0;
         timing_reg <= '0;
      end else begin
         case (phase_reg)
            ST_IDLE: begin
               if (i_req && i_bank_mode == `MODE_ASYNC) begin
                  timing_reg <= i_timing;
                  phase_reg <= ST_PRE_SETUP;
                  count_reg <= i_timing.pre_setup_cycles;
               end
            end
            ST_PRE_SETUP: begin
               count_reg <= count_reg - 8'h01;
               if (last) begin
                  phase_reg <= ST_SETUP;
                  count_reg <= timing_reg.read_setup_cycles;
               end
            end
            ST_SETUP: begin
               count_reg <= count_reg - 8'h01;
               if (last) begin
                  phase_reg <= ST_PRE_ACCESS;
                  count_reg <= timing_reg.pre_access_cycles;
               end
            end
            ST_PRE_ACCESS: begin
               count_reg <= count_reg - 8'h01;
               if (last) begin
                  phase_reg <= ST_ACCESS;
                  count_reg <= timing_reg.read_access_cycles;
               end
            end
            ST_ACCESS: begin
               if (count_reg > 8'h01) begin
                  count_reg <= count_reg - 8'h01;
               end else if (!i_ready_wait_en || ready_s2_reg) begin
                  phase_reg <= ST_HOLD;
                  count_reg <= timing_reg.read_hold_cycles;
               end
            end
            ST_HOLD: begin
               count_reg <= count_reg - 8'h01;
               if (last) begin
                  phase_reg <= ST_IDLE;
               end
            end
            default: phase_reg <= ST_IDLE;
         endcase
      end
   end

   // Pin drivers, registered from next phase
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_addr_bus <= '0;
         o_bank_select_n <= '1;
         o_byte_enable_n <= '1;
         o_output_enable_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
         o_addr_valid_n <= 1'b1;
         o_busy <= 1'b0;
      end else begin
         if (phase_reg == ST_IDLE && i_req && i_bank_mode == `MODE_ASYNC) begin
            o_addr_bus <= i_request.addr;
            o_bank_select_n <= ~i_request.bank;
            o_byte_enable_n <= ~i_request.byte_en;
            o_busy <= 1'b1;
         end else if (phase_reg == ST_HOLD && last) begin
            o_bank_select_n <= '1;
            o_byte_enable_n <= '1;
            o_output_enable_n <= 1'b1;
            o_busy <= 1'b0;
         end
         if (phase_reg == ST_PRE_SETUP && last) begin
            o_addr_valid_n <= 1'b0;
            o_output_enable_n <= 1'b0;
         end
         if (phase_reg == ST_SETUP && last) begin
            o_addr_valid_n <= 1'b1;
         end
         if (phase_reg == ST_PRE_ACCESS && last) begin
            o_read_strobe_n <= 1'b0;
         end
         if (phase_reg == ST_ACCESS && count_reg <= 8'h01
             && (!i_ready_wait_en || ready_s2_reg)) begin
            o_read_strobe_n <= 1'b1;
         end
      end
   end

   // Read data capture at strobe rise
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= '0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (phase_reg == ST_ACCESS && count_reg <= 8'h01
             && (!i_ready_wait_en || ready_s2_reg)) begin
            o_rdata <= data_s2_reg;
            o_done <= 1'b1;
         end
      end
   end

   // Clock mirror enable
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_clkout_en <= 1'b0;
      end else begin
         o_clkout_en <= (i_clkout_source_sel == `CLKOUT_SEL_SYS0);
      end
   end

   sequence s_strobe_two_low;
      !o_read_strobe_n [*2] ##1 o_read_strobe_n;
   endsequence

   property p_strobe_width;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         ($fell(o_read_strobe_n) && !i_ready_wait_en && timing_reg.read_access_cycles == 8'h02)
         |-> s_strobe_two_low;
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");

   property p_ready_release;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         (phase_reg == ST_ACCESS && count_reg <= 8'h01 && ready_s2_reg && i_ready_wait_en)
         |=> o_read_strobe_n;
   endproperty
   a_ready_release: assert property (p_ready_release) else $error("ready release late");

   property p_oe_before_strobe;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         $fell(o_read_strobe_n) |-> !o_output_enable_n && o_addr_valid_n;
   endproperty
   a_oe_before_strobe: assert property (p_oe_before_strobe) else $error("oe not on");

   property p_mode_gate;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         (phase_reg == ST_IDLE && i_bank_mode != `MODE_ASYNC) |=> phase_reg == ST_IDLE;
   endproperty
   a_mode_gate: assert property (p_mode_gate) else $error("non async mode ran");

   property p_hold_stable;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         (phase_reg == ST_HOLD && !last) |=> $stable(o_addr_bus) && !o_output_enable_n;
   endproperty
   a_hold_stable: assert property (p_hold_stable) else $error("hold changed");

   property p_done_data;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         $rose(o_read_strobe_n) |-> o_done;
   endproperty
   a_done_data: assert property (p_done_data) else $error("no capture");

   property p_adv_in_setup;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         (phase_reg == ST_SETUP) |-> !o_addr_valid_n;
   endproperty
   a_adv_in_setup: assert property (p_adv_in_setup) else $error("adv not low");

   property p_order;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         (phase_reg == ST_ACCESS) |=> phase_reg inside {ST_ACCESS, ST_HOLD};
   endproperty
   a_order: assert property (p_order) else $error("phase order broken");

   property p_clkout;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
         (i_clkout_source_sel == `CLKOUT_SEL_SYS0) |=> o_clkout_en;
   endproperty
   a_clkout: assert property (p_clkout) else $error("clock mirror off");
endmodule // async_memory_read_sequencer
`default_nettype wire

// [sim/async_mem_model.sv]
`default_nettype none
module async_mem_model (
   // Memory side
   input wire logic i_clk_sys,
   input wire logic [23:0] i_addr_bus,
   input wire logic i_output_enable_n,
   input wire logic i_read_strobe_n,
   input wire logic [7:0] i_ready_delay,
   output logic [15:0] o_data_bus,
   output logic o_ext_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_reg;
   logic [15:0] last_reg = 16'h0000;
   // Word at once while enabled, inverse of last word when released
   always_ff @(posedge i_clk_sys) begin
      if (!i_output_enable_n) begin
         last_reg <= i_addr_bus[15:0] ^ 16'hA5C3;
      end
   end
   assign o_data_bus = (!i_output_enable_n) ? (i_addr_bus[15:0] ^ 16'hA5C3) : ~last_reg;
   // Ready after set delay in access
   always_ff @(posedge i_clk_sys) begin
      if (i_read_strobe_n) begin
         wait_reg <= 8'h00;
      end else if (wait_reg != 8'hFF) begin
         wait_reg <= wait_reg + 8'h01;
      end
   end
   assign o_ext_ready = !i_read_strobe_n && wait_reg >= i_ready_delay;
endmodule // async_mem_model
`default_nettype wire

// [sim/tb.sv]
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import async_read_pkg::*;
   logic clk = 0, rst_n = 0, rwe = 0, req = 0, busy, done, oe_n, rs_n, av_n, ce, rdy;
   logic [1:0] mode = 0, be_n;
   logic [3:0] sel = 0, bs_n;
   logic [15:0] rdata, dbus;
   logic [23:0] addr;
   logic [7:0] dly = 0;
   timing_type tm = '0;
   request_type rq = '0;
   int n_fail = 0, check_count = 0;
   always #2.5 clk = ~clk;
   async_memory_read_sequencer uut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_bank_mode(mode),
      .i_ready_wait_en(rwe), .i_clkout_source_sel(sel), .i_timing(tm), .i_req(req),
      .i_request(rq), .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_addr_bus(addr),
      .o_bank_select_n(bs_n), .o_byte_enable_n(be_n), .o_output_enable_n(oe_n),
      .o_read_strobe_n(rs_n), .o_addr_valid_n(av_n), .o_clkout_en(ce), .i_data_bus(dbus),
      .i_ext_ready(rdy));
   async_mem_model mem (.i_clk_sys(clk), .i_addr_bus(addr), .i_output_enable_n(oe_n),
      .i_read_strobe_n(rs_n), .i_ready_delay(dly), .o_data_bus(dbus), .o_ext_ready(rdy));
   task finish_test;
      if (n_fail == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] m1(input logic [7:0] x);
      return (x == 8'h00) ? 32'h1 : {24'h0, x};
   endfunction
   function automatic logic [31:0] rel_max(input logic [31:0] lo, input logic [7:0] d);
      return (lo > 32'(d) + 32'h3) ? lo : 32'(d) + 32'h3;
   endfunction
   task automatic rd(input logic [7:0] p, s, a, r, h);
      int k;
      logic fell, bad;
      logic [15:0] dat;
      logic [31:0] nb, no, nv, nr, nh, nd;
      fell = 0;
      bad = 0;
      dat = 0;
      {nb, no, nv, nr, nh, nd} = '0;
      @(posedge clk);
      tm <= '{p, s, a, r, h};
      rq <= 30'($urandom) | 30'h4;
      req <= 1;
      for (k = 0; k < 50 && busy !== 1'b1; k++) @(negedge clk);
      if (busy !== 1'b1) begin
         n_fail++;
         finish_test();
      end
      for (k = 0; k < 3000 && busy === 1'b1; k++) begin
         fell |= rs_n === 1'b0;
         nb += 32'(!fell && bs_n === ~rq.bank);
         no += 32'(!fell && oe_n === 1'b0);
         nv += 32'(!fell && av_n === 1'b0);
         nr += 32'(rs_n === 1'b0);
         nh += 32'(fell && rs_n === 1'b1 && bs_n === ~rq.bank && oe_n === 1'b0);
         nd += 32'(done === 1'b1);
         bad |= bs_n === ~rq.bank && (addr !== rq.addr || be_n !== ~rq.byte_en);
         dat = (done === 1'b1) ? rdata : dat;
         @(posedge clk);
         req <= 0;
         @(negedge clk);
      end
      if (busy === 1'b1) begin
         n_fail++;
         finish_test();
      end
      check("lead", nb, m1(p) + m1(s) + m1(a));
      check("oe_lead", no, m1(s) + m1(a));
      check("valid_low", nv, m1(s));
      check("pre_access", no - nv, m1(a));
      if (rwe) check("ext", 32'(nr >= m1(r) && nr <= rel_max(m1(r), dly)), 1);
      else check("strobe_low", nr, m1(r));
      check("hold", nh, m1(h));
      check("stable", 32'(bad), 0);
      check("rdata", dat, rq.addr[15:0] ^ 16'hA5C3);
      check("done_once", nd, 1);
   endtask
   initial begin
      void'($urandom(32'h1F24));
      repeat (20) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         sel <= 4'(i);
         @(posedge clk);
         @(negedge clk);
         check("clkout", ce, i == 3);
      end
      for (int m = 1; m < 4; m++) begin
         @(posedge clk);
         mode <= 2'(m);
         req <= 1;
         repeat (4) @(negedge clk);
         check("refused", busy, 0);
      end
      @(posedge clk);
      mode <= 0;
      req <= 0;
      rd(0, 0, 0, 0, 0);
      rd(8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      repeat (20) rd(8'($urandom_range(7)), 8'($urandom_range(7)), 8'($urandom_range(7)),
         8'($urandom_range(7)), 8'($urandom_range(7)));
      @(posedge clk);
      rwe <= 1;
      repeat (8) begin
         @(posedge clk);
         dly <= 8'($urandom_range(12));
         rd(1, 2, 1, 6, 1);
      end
      finish_test();
   end
endmodule // tb
`default_nettype wire
